// ==== hw/rcsr_regs.sv ====
// Regulator control and status register bank: live faults, mode and voltage select
`timescale 1ns/10ps
`include "rcsr_consts.svh"
module rcsr_regs (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rd_data,
   input wire logic oc_fault_declared,
   input wire logic startup_timeout_declared,
   input wire logic short_fault_declared,
   input wire logic undervoltage_lockout_cmp,
   input wire logic over_temp_cmp,
   output logic regulation_enable,
   output logic forced_fixed_frequency,
   output logic [6:0] output_voltage_select,
   output logic [11:0] vout_target_mv,
   output logic vout_code_reserved
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic rcsr_pkg::rcsr_sel_t rcsr_decode(input logic [7:0] addr);
      rcsr_pkg::rcsr_sel_t sel;
      if (addr == `RCSR_ADDR_LIVE)
      begin
         sel = rcsr_pkg::RCSR_SEL_LIVE;
      end
      else if (addr == `RCSR_ADDR_MODE)
      begin
         sel = rcsr_pkg::RCSR_SEL_MODE;
      end
      else if (addr == `RCSR_ADDR_VOLT_SEL)
      begin
         sel = rcsr_pkg::RCSR_SEL_VOLT;
      end
      else
      begin
         sel = rcsr_pkg::RCSR_SEL_NONE;
      end
      return sel;
   endfunction

   function automatic logic rcsr_code_reserved(input logic [6:0] code);
      return (code < `RCSR_VOLT_SEL_MIN_CODE) || (code > `RCSR_VOLT_SEL_MAX_CODE);
   endfunction

   // Reserved codes give 0 mV so the loop never sees a bogus target
   function automatic logic [11:0] rcsr_code_to_mv(input logic [6:0] code);
      logic [11:0] steps;
      logic [23:0] prod;
      steps = {5'h00, code} - {5'h00, `RCSR_VOLT_SEL_MIN_CODE};
      prod = steps * `RCSR_VOUT_STEP_MV;
      if (rcsr_code_reserved(code))
      begin
         return `RCSR_VOUT_NONE_MV;
      end
      return `RCSR_VOUT_BASE_MV + prod[11:0];
   endfunction

   // ----------------------------------------------------------------------
   // Live fault capture
   // ----------------------------------------------------------------------
   rcsr_fault_if fault_bus ();

   assign fault_bus.declared = {oc_fault_declared, startup_timeout_declared,
                                short_fault_declared};

   rcsr_live_capture u_live (
      .clk(clk),
      .srst(srst),
      .fault(fault_bus.capture)
   );

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   rcsr_pkg::rcsr_sel_t wr_sel;
   rcsr_pkg::rcsr_sel_t rd_sel;
   logic [1:0] mode_q;
   logic [1:0] mode_d;
   logic [6:0] volt_sel_q;
   logic [6:0] volt_sel_d;

   assign wr_sel = rcsr_decode(reg_addr);
   assign rd_sel = rcsr_decode(reg_addr);

   // Writes to the live register or to unmapped offsets are dropped
   always_comb
   begin
      mode_d = mode_q;
      volt_sel_d = volt_sel_q;
      if (reg_wr_en)
      begin
         if (wr_sel == rcsr_pkg::RCSR_SEL_MODE)
         begin
            mode_d = reg_wr_data[1:0];
         end
         else if (wr_sel == rcsr_pkg::RCSR_SEL_VOLT)
         begin
            volt_sel_d = reg_wr_data[6:0];
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mode_q <= `RCSR_MODE_RESET;
         volt_sel_q <= `RCSR_VOLT_SEL_RESET;
      end
      else
      begin
         mode_q <= mode_d;
         volt_sel_q <= volt_sel_d;
      end
   end

   assign regulation_enable = mode_q[`RCSR_MODE_EN_BIT];
   assign forced_fixed_frequency = mode_q[`RCSR_MODE_FPWM_BIT];
   assign output_voltage_select = volt_sel_q;

   // ----------------------------------------------------------------------
   // Voltage target decode
   // ----------------------------------------------------------------------
   logic [11:0] mv_q;
   logic [11:0] mv_d;
   logic rsv_q;
   logic rsv_d;

   // Registered so the target changes one cycle after the code, glitch free
   always_comb
   begin
      mv_d = rcsr_code_to_mv(volt_sel_q);
      rsv_d = rcsr_code_reserved(volt_sel_q);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mv_q <= `RCSR_VOUT_NONE_MV;
         rsv_q <= 1'h0;
      end
      else
      begin
         mv_q <= mv_d;
         rsv_q <= rsv_d;
      end
   end

   assign vout_target_mv = mv_q;
   assign vout_code_reserved = rsv_q;

   // ----------------------------------------------------------------------
   // Live status word and read port
   // ----------------------------------------------------------------------
   logic [7:0] live_word;
   logic [7:0] rd_q;
   logic [7:0] rd_d;

   // Comparators are meaningless while shut down, so report fault then
   always_comb
   begin
      live_word = `RCSR_READ_ZERO;
      live_word[`RCSR_LIVE_UV_LOCK_BIT] = regulation_enable ? undervoltage_lockout_cmp
                                                         : 1'h1;
      live_word[`RCSR_LIVE_OT_BIT] = regulation_enable ? over_temp_cmp : 1'h1;
      live_word[`RCSR_LIVE_OC_BIT] = fault_bus.live[2];
      live_word[`RCSR_LIVE_STO_BIT] = fault_bus.live[1];
      live_word[`RCSR_LIVE_SHORT_BIT] = fault_bus.live[0];
   end

   // The read word holds until the next read; unmapped offsets read zero
   always_comb
   begin
      rd_d = rd_q;
      if (reg_rd_en)
      begin
         if (rd_sel == rcsr_pkg::RCSR_SEL_LIVE)
         begin
            rd_d = live_word;
         end
         else if (rd_sel == rcsr_pkg::RCSR_SEL_MODE)
         begin
            rd_d = {6'h00, mode_q};
         end
         else if (rd_sel == rcsr_pkg::RCSR_SEL_VOLT)
         begin
            rd_d = {1'h0, volt_sel_q};
         end
         else
         begin
            rd_d = `RCSR_READ_ZERO;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rd_q <= `RCSR_READ_ZERO;
      end
      else
      begin
         rd_q <= rd_d;
      end
   end

   assign reg_rd_data = rd_q;

endmodule

// ==== hw/rcsr_consts.svh ====
// Register offsets, field positions and reset values of the regulator register bank
`ifndef RCSR_CONSTS_SVH
`define RCSR_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RCSR_ADDR_LIVE 8'h02
`define RCSR_ADDR_MODE 8'h03
`define RCSR_ADDR_VOLT_SEL 8'h04

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RCSR_LIVE_UV_LOCK_BIT 4
`define RCSR_LIVE_OT_BIT 3
`define RCSR_LIVE_OC_BIT 2
`define RCSR_LIVE_STO_BIT 1
`define RCSR_LIVE_SHORT_BIT 0
`define RCSR_MODE_EN_BIT 1
`define RCSR_MODE_FPWM_BIT 0

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define RCSR_MODE_RESET 2'h0
`define RCSR_VOLT_SEL_RESET 7'h7B
`define RCSR_LIVE_RESET 3'h0
`define RCSR_VOLT_SEL_MIN_CODE 7'h0F
`define RCSR_VOLT_SEL_MAX_CODE 7'h7B
`define RCSR_VOUT_NONE_MV 12'h000
`define RCSR_VOUT_BASE_MV 12'h258
`define RCSR_VOUT_STEP_MV 12'h019
`define RCSR_READ_ZERO 8'h00

`endif

// ==== hw/rcsr_pkg.sv ====
// Types shared by the regulator register bank modules
package rcsr_pkg;

   // Register selected by a host access
   typedef enum logic [1:0] {
      RCSR_SEL_NONE,
      RCSR_SEL_LIVE,
      RCSR_SEL_MODE,
      RCSR_SEL_VOLT
   } rcsr_sel_t;

   // Live flag vector: short, startup timeout, over-current (bit 0 upward)
   typedef logic [2:0] rcsr_live_t;

endpackage

// ==== hw/rcsr_fault_if.sv ====
// Fault-declared strobes and the captured live flags between the bank modules
`timescale 1ns/10ps
interface rcsr_fault_if;
   rcsr_pkg::rcsr_live_t declared;
   rcsr_pkg::rcsr_live_t live;

   modport capture (
      input declared,
      output live
   );

   modport bank (
      output declared,
      input live
   );
endinterface

// ==== hw/rcsr_live_capture.sv ====
// One-cycle capture of the fault-declared strobes into the live flags
`timescale 1ns/10ps
`include "rcsr_consts.svh"
module rcsr_live_capture (
   input wire logic clk,
   input wire logic srst,
   rcsr_fault_if.capture fault
);

   rcsr_pkg::rcsr_live_t live_q;
   rcsr_pkg::rcsr_live_t live_d;

   // ----------------------------------------------------------------------
   // Capture
   // ----------------------------------------------------------------------
   // A flag is 1 only in the cycle after its declaration strobe; with no new
   // strobe it falls back to 0 while the fault machine holds its fault state.
   always_comb
   begin
      live_d = fault.declared;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         live_q <= `RCSR_LIVE_RESET;
      end
      else
      begin
         live_q <= live_d;
      end
   end

   assign fault.live = live_q;

endmodule

// ==== testbench/rcsr_regs_props.sv ====
// Concurrent checks on the ports of the regulator register bank
`timescale 1ns/10ps
module rcsr_regs_props (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wr_data,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_rd_data,
   input wire logic oc_fault_declared,
   input wire logic startup_timeout_declared,
   input wire logic short_fault_declared,
   input wire logic undervoltage_lockout_cmp,
   input wire logic over_temp_cmp,
   input wire logic regulation_enable,
   input wire logic forced_fixed_frequency,
   input wire logic [6:0] output_voltage_select,
   input wire logic [11:0] vout_target_mv,
   input wire logic vout_code_reserved
);
   // ---------------------------------------------------------------
   // Port checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   logic [6:0] code_q;
   logic rsv;
   logic wr_mode;
   logic wr_code;
   assign rsv = code_q < 7'h0F || code_q > 7'h7B;
   assign wr_mode = reg_wr_en && reg_addr == 8'h03;
   assign wr_code = reg_wr_en && reg_addr == 8'h04;
   always_ff @(posedge clk) code_q <= output_voltage_select;
   reset_values_a:
      assert property ($past(srst) |-> !regulation_enable && !forced_fixed_frequency &&
         output_voltage_select == 7'h7B && reg_rd_data == 8'h00)
      else $error("register reset values wrong");
   live_flags_a:
      assert property (reg_rd_en && reg_addr == 8'h02 && !$past(srst) |=> reg_rd_data[2:0] ==
         $past({oc_fault_declared, startup_timeout_declared, short_fault_declared}, 2))
      else $error("live fault flags wrong");
   fault_mask_a:
      assert property (reg_rd_en && reg_addr == 8'h02 |=> reg_rd_data[7:3] == {3'h0,
         $past(regulation_enable) ? $past({undervoltage_lockout_cmp, over_temp_cmp}) : 2'h3})
      else $error("live comparator bits wrong");
   enable_bit_a:
      assert property (wr_mode |=> regulation_enable == $past(reg_wr_data[1]))
      else $error("enable bit not written");
   fixed_freq_a:
      assert property (wr_mode |=> forced_fixed_frequency == $past(reg_wr_data[0]))
      else $error("fixed frequency bit not written");
   code_write_a:
      assert property (wr_code |=> output_voltage_select == $past(reg_wr_data[6:0]))
      else $error("voltage code not written");
   code_read_a:
      assert property (reg_rd_en && reg_addr == 8'h04 |=>
         reg_rd_data == {1'h0, $past(output_voltage_select)})
      else $error("voltage code readback wrong");
   vout_map_a:
      assert property (!$past(srst) |->
         vout_target_mv == (rsv ? 12'h000 : 12'h258 + 12'h019 * {5'h0, code_q - 7'h0F}))
      else $error("target millivolts wrong");
   code_reserved_a:
      assert property (!$past(srst) |-> vout_code_reserved == rsv)
      else $error("reserved code flag wrong");
endmodule

bind rcsr_regs rcsr_regs_props u_props (.clk(clk), .srst(srst), .reg_addr(reg_addr),
   .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
   .reg_rd_data(reg_rd_data), .oc_fault_declared(oc_fault_declared),
   .startup_timeout_declared(startup_timeout_declared),
   .short_fault_declared(short_fault_declared),
   .undervoltage_lockout_cmp(undervoltage_lockout_cmp), .over_temp_cmp(over_temp_cmp),
   .regulation_enable(regulation_enable), .forced_fixed_frequency(forced_fixed_frequency),
   .output_voltage_select(output_voltage_select), .vout_target_mv(vout_target_mv),
   .vout_code_reserved(vout_code_reserved));

// ==== testbench/rcsr_host.sv ====
// Parallel host model issuing byte register accesses
`timescale 1ns/10ps
module rcsr_host (
   input wire logic clk,
   output logic [7:0] addr,
   output logic wr_en,
   output logic [7:0] wr_data,
   output logic rd_en,
   input wire logic [7:0] rd_data
);
   // ---------------------------------------------------------------
   // Byte access
   // ---------------------------------------------------------------
   initial
   begin
      {addr, wr_en, wr_data, rd_en} = {8'hFF, 1'h0, 8'h00, 1'h0};
   end
   // Called at a falling edge; released lines flip so stale values never look valid
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      addr = a;
      wr_data = d;
      wr_en = w;
      rd_en = !w;
      @(negedge clk);
      q = rd_data;
      {wr_en, rd_en, addr, wr_data} = {1'h0, 1'h0, ~a, ~d};
      @(negedge clk);
   endtask
endmodule

// ==== testbench/regulator_control_status_regs_bench.sv ====
// Self-checking bench of the regulator register bank
`timescale 1ns/10ps
module regulator_control_status_regs_bench;
   logic clk, srst, uv, ot, en, ffm, rsv, wr_en, rd_en, r;
   logic [2:0] dec;
   logic [7:0] addr, wdata, rdata, q;
   logic [6:0] volt_sel;
   logic [11:0] mv;
   logic [6:0] codes [8] = '{7'h00, 7'h0E, 7'h0F, 7'h10, 7'h72, 7'h7B, 7'h7C, 7'h7F};
   int miscompares = 0;
   int comparisons = 0;
   rcsr_regs u_rcsr_regs (.clk(clk), .srst(srst), .reg_addr(addr), .reg_wr_en(wr_en),
      .reg_wr_data(wdata), .reg_rd_en(rd_en), .reg_rd_data(rdata), .oc_fault_declared(dec[2]),
      .startup_timeout_declared(dec[1]), .short_fault_declared(dec[0]),
      .undervoltage_lockout_cmp(uv), .over_temp_cmp(ot), .regulation_enable(en),
      .forced_fixed_frequency(ffm), .output_voltage_select(volt_sel), .vout_target_mv(mv),
      .vout_code_reserved(rsv));
   rcsr_host u_rcsr_host (.clk(clk), .addr(addr), .wr_en(wr_en), .wr_data(wdata),
      .rd_en(rd_en), .rd_data(rdata));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_rcsr_host.acc(1'h1, a, d, q);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      u_rcsr_host.acc(1'h0, a, 8'h00, q);
      chk({4'h0, q}, {4'h0, e});
   endtask
   task automatic print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   // About 80 cycles are needed; allow nearly twenty times that
   initial
   begin
      #150000;
      miscompares++;
      print_verdict;
   end
   initial
   begin
      {srst, uv, ot, dec} = {1'h1, 1'h0, 1'h0, 3'h0};
      repeat (4) @(negedge clk);
      srst = 1'h0;
      chk({3'h0, en, ffm, volt_sel}, 12'h07B);
      chk({11'h0, rsv}, 12'h000);
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h7B);
      rd(8'h02, 8'h18);
      chk(mv, 12'hCE4);
      $display("reset values done");
      wr(8'h03, 8'hFF);
      chk({10'h0, en, ffm}, 12'h003);
      rd(8'h03, 8'h03);
      wr(8'h03, 8'h02);
      chk({10'h0, en, ffm}, 12'h002);
      wr(8'h02, 8'hFF);
      rd(8'h09, 8'h00);
      $display("mode register done");
      for (int i = 0; i < 4; i++)
      begin
         {uv, ot} = i[1:0];
         rd(8'h02, {3'h0, i[1:0], 3'h0});
      end
      {uv, ot} = 2'h0;
      for (int i = 0; i < 3; i++)
      begin
         dec = 3'h1 << i;
         @(negedge clk);
         dec = 3'h0;
         rd(8'h02, 8'h01 << i);
         rd(8'h02, 8'h00);
      end
      $display("live status done");
      foreach (codes[k])
      begin
         wr(8'h04, {1'h1, codes[k]});
         chk({5'h0, volt_sel}, {5'h0, codes[k]});
         rd(8'h04, {1'h0, codes[k]});
         r = codes[k] < 7'h0F || codes[k] > 7'h7B;
         chk({11'h0, rsv}, {11'h0, r});
         chk(mv, r ? 12'h000 : 12'h258 + 12'h019 * {5'h0, codes[k] - 7'h0F});
      end
      $display("voltage select done");
      // Reset after writes proves the reset branch, not just power-up values
      srst = 1'h1;
      @(negedge clk);
      srst = 1'h0;
      chk({3'h0, en, ffm, volt_sel}, 12'h07B);
      rd(8'h02, 8'h18);
      chk(mv, 12'hCE4);
      $display("mid-run reset done");
      print_verdict;
   end
endmodule
